/* hw/pbso_pkg.sv */
package pbso_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS   = 4;
	localparam int FAULT_PULSE_US  = 128;
	localparam int FAULT_PULSE_CYC = (FAULT_PULSE_US * 1000) / CLK_PERIOD_NS;
	localparam int MS_TICK_CYC     = 1000000 / CLK_PERIOD_NS;
	localparam int RESET_HOLD_MS   = 400;
	localparam int MS_CNT_W        = 18;
	localparam int PULSE_CNT_W     = 16;
	localparam int PRESS_W         = 16;
	localparam int HOLD_W          = 10;

	// long_press_time choices in ms, picked by long_press_setting
	localparam logic [15:0] LONG_PRESS_MS0 = 16'h1388;
	localparam logic [15:0] LONG_PRESS_MS1 = 16'h2710;
	localparam logic [15:0] LONG_PRESS_MS2 = 16'h3a98;
	localparam logic [15:0] LONG_PRESS_MS3 = 16'h4e20;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MK = 8'h0c;
	localparam logic [7:0] ADDR_WAKE   = 8'h10;
	localparam logic [7:0] ADDR_TSTH   = 8'h14;
	localparam logic [7:0] ADDR_TERM   = 8'h18;

	// ==========================================================
	// control fields
	localparam int CTRL_IND_EN  = 0;
	localparam int CTRL_MIRROR  = 1;
	localparam int CTRL_LP_LO   = 2;
	localparam int CTRL_SHIP    = 4;

	// interrupt bit positions
	localparam int IRQ_W       = 5;
	localparam int IRQ_FAULT   = 0;
	localparam int IRQ_WAKE1   = 1;
	localparam int IRQ_WAKE2   = 2;
	localparam int IRQ_LONG    = 3;
	localparam int IRQ_SHIPX   = 4;

	// reset values and termination limits
	localparam logic [7:0]  WAKE1_RST = 8'h32;
	localparam logic [7:0]  WAKE2_RST = 8'hc8;
	localparam logic [31:0] TSTH_RST  = 32'hc0_a0_60_40;
	localparam logic [4:0]  TERM_MIN  = 5'h05;
	localparam logic [4:0]  TERM_MAX  = 5'h14;
	localparam logic [4:0]  TERM_RST  = 5'h0a;

	// thermistor zones: below first threshold is coldest
	localparam logic [2:0] ZONE_COLD = 3'h0;
	localparam logic [2:0] ZONE_HOT  = 3'h4;

endpackage

/* hw/pbso_top.sv */
// What this block does
// - status pin low while charge cycle runs
// - status pin released when done, disabled, high-Z
// - fault gives one 128us low pulse
// - indicator_enable gates charge indication
// - power_good low while input within limits
// - mirror mode makes power_good follow button
// - reset asserted after long press
// - reset released after 400ms hold
// - two programmable wake interrupts on short press
// - button press exits ship mode
// - thermistor sorted on four thresholds, fault reported
// - termination setting doubles as precharge, 5-20%
`timescale 1ns/100ps
`default_nettype none

module pbso_top import pbso_pkg::*; #(
	parameter int MS_TICK  = MS_TICK_CYC,
	parameter int FLT_CYC  = FAULT_PULSE_CYC
) (
	// clock and reset
	input  wire logic        MCLK_I,
	input  wire logic        RST_N_I,
	// apb slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic             PREADY_O,
	output logic [31:0]      PRDATA_O,
	output logic             PSLVERR_O,
	// charger status
	input  wire logic        CHARGING_I,
	input  wire logic        CHG_DONE_I,
	input  wire logic        CHG_DISABLE_I,
	input  wire logic        HIZ_I,
	input  wire logic        FAULT_I,
	input  wire logic        VIN_ABOVE_SLEEP_I,
	input  wire logic        VIN_OVP_I,
	input  wire logic [7:0]  THERM_LEVEL_I,
	// push-button
	input  wire logic        PUSHBUTTON_N_I,
	// open-drain pins
	output logic             STAT_INT_O,
	output logic             STAT_INT_OE_N_O,
	output logic             POWER_GOOD_O,
	output logic             POWER_GOOD_OE_N_O,
	output logic             RESET_N_O,
	output logic             RESET_OE_N_O,
	// other outputs
	output logic             IRQ_O,
	output logic             SHIP_MODE_O,
	output logic [4:0]       TERM_SET_O,
	output logic [4:0]       PRECHG_SET_O
);

	// ==========================================================
	// state
	typedef struct packed {
		logic                   pready;
		logic [31:0]            prdata;
		logic                   pslverr;
		logic                   ind_en;
		logic                   mirror;
		logic [1:0]             lp_sel;
		logic [7:0]             wake1;
		logic [7:0]             wake2;
		logic [31:0]            tsth;
		logic [4:0]             term;
		logic [IRQ_W-1:0]       irq_st;
		logic [IRQ_W-1:0]       irq_mk;
		logic                   irq;
		logic                   ship;
		logic [MS_CNT_W-1:0]    ms_cnt;
		logic                   ms_tick;
		logic [PRESS_W-1:0]     press_ms;
		logic                   w1_done;
		logic                   w2_done;
		logic                   lp_done;
		logic                   rst_act;
		logic [HOLD_W-1:0]      hold_ms;
		logic [PULSE_CNT_W-1:0] pulse_cnt;
		logic                   fault_d;
		logic                   tsf_d;
		logic [2:0]             zone;
		logic                   ts_fault;
		logic                   stat_oe_n;
		logic                   pg_oe_n;
		logic                   rst_oe_n;
	} pbso_state_t;

	pbso_state_t st_reg;
	pbso_state_t st_next;

	logic [15:0]      lp_ms;
	logic [IRQ_W-1:0] ev;
	logic [31:0]      rdata;
	logic             hit;
	logic             wr;
	logic             pressed;
	logic             flt_ev;
	logic [2:0]       zone_c;
	logic [4:0]       term_w;

	// ==========================================================
	// combinational next state
	always_comb begin
		st_next = st_reg;
		ev      = '0;
		term_w  = '0;
		pressed = ~PUSHBUTTON_N_I;

		case (st_reg.lp_sel)
			2'h0:    lp_ms = LONG_PRESS_MS0;
			2'h1:    lp_ms = LONG_PRESS_MS1;
			2'h2:    lp_ms = LONG_PRESS_MS2;
			default: lp_ms = LONG_PRESS_MS3;
		endcase

		// 1 ms enable; long times count in ms to keep counters narrow
		st_next.ms_tick = 1'b0;
		if (st_reg.ms_cnt >= MS_CNT_W'(MS_TICK - 1)) begin
			st_next.ms_cnt  = '0;
			st_next.ms_tick = 1'b1;
		end else begin
			st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
		end

		// press timing
		if (!pressed) begin
			st_next.press_ms = '0;
			st_next.w1_done  = 1'b0;
			st_next.w2_done  = 1'b0;
			st_next.lp_done  = 1'b0;
		end else if (st_reg.ms_tick && !st_reg.lp_done) begin
			st_next.press_ms = st_reg.press_ms + 1'b1;
		end
		if (pressed && !st_reg.lp_done) begin
			if (!st_reg.w1_done && st_reg.press_ms > {8'h00, st_reg.wake1}) begin
				st_next.w1_done = 1'b1;
				ev[IRQ_WAKE1]   = 1'b1;
			end
			if (!st_reg.w2_done && st_reg.press_ms > {8'h00, st_reg.wake2}) begin
				st_next.w2_done = 1'b1;
				ev[IRQ_WAKE2]   = 1'b1;
			end
			if (st_reg.press_ms > lp_ms) begin
				st_next.lp_done = 1'b1;
				st_next.rst_act = 1'b1;
				st_next.hold_ms = '0;
				ev[IRQ_LONG]    = 1'b1;
			end
		end

		// reset hold; a new long press needs a release first
		if (st_reg.rst_act && st_reg.ms_tick) begin
			if (st_reg.hold_ms >= HOLD_W'(RESET_HOLD_MS - 1)) begin
				st_next.rst_act = 1'b0;
			end else begin
				st_next.hold_ms = st_reg.hold_ms + 1'b1;
			end
		end
		st_next.rst_oe_n = ~st_next.rst_act;

		// ship mode exit
		if (st_reg.ship && pressed) begin
			st_next.ship    = 1'b0;
			ev[IRQ_SHIPX]   = 1'b1;
		end

		// thermistor zone: count thresholds the level lies above
		zone_c = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (THERM_LEVEL_I > st_reg.tsth[i*8 +: 8]) begin
				zone_c = zone_c + 3'h1;
			end
		end
		st_next.zone     = zone_c;
		st_next.ts_fault = CHARGING_I
			&& (zone_c == ZONE_COLD || zone_c == ZONE_HOT);

		// fault edges start one pulse; a fault during a pulse is merged
		st_next.fault_d = FAULT_I;
		st_next.tsf_d   = st_reg.ts_fault;
		flt_ev = (FAULT_I && !st_reg.fault_d)
			|| (st_reg.ts_fault && !st_reg.tsf_d);
		if (flt_ev) begin
			ev[IRQ_FAULT] = 1'b1;
			if (st_reg.pulse_cnt == '0) begin
				st_next.pulse_cnt = PULSE_CNT_W'(FLT_CYC);
			end
		end else if (st_reg.pulse_cnt != '0) begin
			st_next.pulse_cnt = st_reg.pulse_cnt - 1'b1;
		end

		// status pin: indicator only while a cycle actually runs
		st_next.stat_oe_n = ~((st_next.pulse_cnt != '0)
			|| (st_reg.ind_en
			&& CHARGING_I && !CHG_DONE_I
			&& !CHG_DISABLE_I && !HIZ_I));

		// power good pin
		if (st_reg.mirror) begin
			st_next.pg_oe_n = PUSHBUTTON_N_I;
		end else begin
			st_next.pg_oe_n = ~(VIN_ABOVE_SLEEP_I && !VIN_OVP_I);
		end

		// ======================================================
		// apb: answer in second access cycle
		wr  = PSEL_I && PENABLE_I && st_reg.pready && PWRITE_I;
		hit = 1'b1;
		rdata = '0;
		case (PADDR_I)
			ADDR_CTRL:   rdata = {27'h0, st_reg.ship, st_reg.lp_sel,
				st_reg.mirror, st_reg.ind_en};
			ADDR_STATUS: rdata = {23'h0, pressed, st_reg.ts_fault,
				st_reg.zone, st_reg.ship, st_reg.rst_act,
				~st_reg.pg_oe_n, CHARGING_I};
			ADDR_IRQ_ST: rdata = {27'h0, st_reg.irq_st};
			ADDR_IRQ_MK: rdata = {27'h0, st_reg.irq_mk};
			ADDR_WAKE:   rdata = {16'h0, st_reg.wake2, st_reg.wake1};
			ADDR_TSTH:   rdata = st_reg.tsth;
			ADDR_TERM:   rdata = {27'h0, st_reg.term};
			default:     hit = 1'b0;
		endcase
		st_next.pready  = PSEL_I && PENABLE_I && !st_reg.pready;
		st_next.pslverr = st_next.pready && !hit;
		st_next.prdata  = (st_next.pready && !PWRITE_I) ? rdata : '0;

		// write 1 to clear; a same-cycle event wins
		st_next.irq_st = st_reg.irq_st;
		if (wr && PADDR_I == ADDR_IRQ_ST) begin
			st_next.irq_st = st_reg.irq_st & ~PWDATA_I[IRQ_W-1:0];
		end
		st_next.irq_st = st_next.irq_st | ev;

		if (wr) begin
			case (PADDR_I)
				ADDR_CTRL: begin
					st_next.ind_en = PWDATA_I[CTRL_IND_EN];
					st_next.mirror = PWDATA_I[CTRL_MIRROR];
					st_next.lp_sel = PWDATA_I[CTRL_LP_LO +: 2];
					if (PWDATA_I[CTRL_SHIP] && !pressed) begin
						st_next.ship = 1'b1;
					end
				end
				ADDR_IRQ_MK: st_next.irq_mk = PWDATA_I[IRQ_W-1:0];
				ADDR_WAKE: begin
					st_next.wake1 = PWDATA_I[7:0];
					st_next.wake2 = PWDATA_I[15:8];
				end
				ADDR_TSTH: st_next.tsth = PWDATA_I;
				ADDR_TERM: begin
					term_w = PWDATA_I[4:0];
					if (term_w < TERM_MIN) begin
						term_w = TERM_MIN;
					end else if (term_w > TERM_MAX) begin
						term_w = TERM_MAX;
					end
					st_next.term = term_w;
				end
				default: ;
			endcase
		end
		st_next.irq = |(st_next.irq_st & st_next.irq_mk);
	end

	// ==========================================================
	// state register
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			st_reg           <= '0;
			st_reg.ind_en    <= 1'b1;
			st_reg.wake1     <= WAKE1_RST;
			st_reg.wake2     <= WAKE2_RST;
			st_reg.tsth      <= TSTH_RST;
			st_reg.term      <= TERM_RST;
			st_reg.stat_oe_n <= 1'b1;
			st_reg.pg_oe_n   <= 1'b1;
			st_reg.rst_oe_n  <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs, all straight from the state register
	assign PREADY_O          = st_reg.pready;
	assign PRDATA_O          = st_reg.prdata;
	assign PSLVERR_O         = st_reg.pslverr;
	// open-drain pins only ever pull low
	assign STAT_INT_O        = st_reg.rst_act & ~st_reg.rst_act;
	assign STAT_INT_OE_N_O   = st_reg.stat_oe_n;
	assign POWER_GOOD_O      = STAT_INT_O;
	assign POWER_GOOD_OE_N_O = st_reg.pg_oe_n;
	assign RESET_N_O         = STAT_INT_O;
	assign RESET_OE_N_O      = st_reg.rst_oe_n;
	assign IRQ_O             = st_reg.irq;
	assign SHIP_MODE_O       = st_reg.ship;
	assign TERM_SET_O        = st_reg.term;
	assign PRECHG_SET_O      = st_reg.term;

endmodule

`default_nettype wire

/* tb/pbso_host.sv */
`timescale 1ns/100ps
`default_nettype none

module pbso_host (
	// clock
	input  wire logic clk,
	// open-drain enables from the device
	input  wire logic stat_oe_n,
	input  wire logic pg_oe_n,
	input  wire logic rst_oe_n,
	// resolved pin levels and timed pulse
	output logic      stat_lvl,
	output logic      pg_lvl,
	output logic      rst_lvl,
	output int        low_len
);
	// ==========================================================
	// pull-ups: a released pin reads high
	assign stat_lvl = stat_oe_n;
	assign pg_lvl   = pg_oe_n;
	assign rst_lvl  = rst_oe_n;

	// host times each completed low run on the status pin
	int run = 0;
	always @(posedge clk) begin
		run <= stat_oe_n ? 0 : run + 1;
		if (stat_oe_n && run != 0) begin
			low_len <= run;
		end
	end
endmodule

`default_nettype wire

/* tb/pbso_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module pbso_top_assertions #(
	parameter int MS_TICK = 10,
	parameter int FLT_CYC = 8
) (
	// clock, reset and inputs
	input  wire logic       MCLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       CHARGING_I,
	input  wire logic       FAULT_I,
	input  wire logic       VIN_ABOVE_SLEEP_I,
	input  wire logic       VIN_OVP_I,
	input  wire logic       PUSHBUTTON_N_I,
	// outputs watched
	input  wire logic       STAT_INT_OE_N_O,
	input  wire logic       POWER_GOOD_OE_N_O,
	input  wire logic       RESET_OE_N_O,
	input  wire logic       SHIP_MODE_O,
	input  wire logic [4:0] TERM_SET_O,
	input  wire logic [4:0] PRECHG_SET_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	// ==========================================================
	// helper counters
	int q_cnt, lo_cnt, r_cnt, p_cnt;
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			q_cnt <= 0;
			lo_cnt <= 0;
			r_cnt <= 0;
			p_cnt <= 0;
		end else begin
			q_cnt <= (FAULT_I || CHARGING_I) ? 0 : q_cnt + 1;
			lo_cnt <= (STAT_INT_OE_N_O || CHARGING_I) ? 0 : lo_cnt + 1;
			r_cnt <= RESET_OE_N_O ? 0 : r_cnt + 1;
			p_cnt <= PUSHBUTTON_N_I ? 0 : p_cnt + 1;
		end
	end

	// ==========================================================
	// properties
	sequence s_low;
		!STAT_INT_OE_N_O [*2];
	endsequence
	a_pg_source: assert property (
		!POWER_GOOD_OE_N_O |-> !$past(PUSHBUTTON_N_I) ||
		($past(VIN_ABOVE_SLEEP_I) && !$past(VIN_OVP_I)))
		else $error("power good pulled without cause");
	a_stat_quiet: assert property (
		q_cnt > FLT_CYC + 2 |-> STAT_INT_OE_N_O)
		else $error("status pin low while idle");
	a_pulse_start: assert property (
		$rose(FAULT_I) && q_cnt > FLT_CYC + 2 |-> ##[1:2] s_low)
		else $error("fault pulse missing");
	a_pulse_max: assert property (
		lo_cnt <= FLT_CYC)
		else $error("fault pulse too long");
	a_reset_cause: assert property (
		$fell(RESET_OE_N_O) |-> p_cnt >= 5000 * MS_TICK - 2)
		else $error("reset without long press");
	a_reset_hold: assert property (
		$rose(RESET_OE_N_O) |->
		r_cnt >= 399 * MS_TICK && r_cnt <= 401 * MS_TICK)
		else $error("reset hold length wrong");
	a_ship_exit: assert property (
		SHIP_MODE_O && !PUSHBUTTON_N_I |-> ##[1:3] !SHIP_MODE_O)
		else $error("ship mode not left on press");
	a_term_pair: assert property (
		TERM_SET_O == PRECHG_SET_O && TERM_SET_O inside {[5:20]})
		else $error("precharge differs from termination");
endmodule

bind pbso_top pbso_top_assertions #(
	.MS_TICK(MS_TICK),
	.FLT_CYC(FLT_CYC)
) u_chk (.*);

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb import pbso_pkg::*;;
	localparam int TK = 10;
	localparam int FC = 8;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic        chg = 0, done = 0, dis = 0, hiz = 0, flt = 0;
	logic        vin = 0, ovp = 0, btn_n = 1, e;
	logic [7:0]  padr = 8'h00, therm = 8'h80;
	logic [31:0] pwd = 32'h0, prd, r;
	logic        prdy, perr, st_oe, pg_oe, rs_oe, irq, ship, st_l, pg_l, rs_l;
	logic [4:0]  term, pre;
	logic        st_d, pg_d, rs_d;
	int          mismatches = 0, checks = 0, lo_len, i;
	always #2 clk = ~clk;

	pbso_top #(.MS_TICK(TK), .FLT_CYC(FC)) u_dut (
		.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PREADY_O(prdy),
		.PRDATA_O(prd), .PSLVERR_O(perr), .CHARGING_I(chg),
		.CHG_DONE_I(done), .CHG_DISABLE_I(dis), .HIZ_I(hiz), .FAULT_I(flt),
		.VIN_ABOVE_SLEEP_I(vin), .VIN_OVP_I(ovp), .THERM_LEVEL_I(therm),
		.PUSHBUTTON_N_I(btn_n), .STAT_INT_O(st_d), .STAT_INT_OE_N_O(st_oe),
		.POWER_GOOD_O(pg_d), .POWER_GOOD_OE_N_O(pg_oe), .RESET_N_O(rs_d),
		.RESET_OE_N_O(rs_oe), .IRQ_O(irq), .SHIP_MODE_O(ship),
		.TERM_SET_O(term), .PRECHG_SET_O(pre));
	pbso_host u_host (.clk(clk), .stat_oe_n(st_oe), .pg_oe_n(pg_oe),
		.rst_oe_n(rs_oe), .stat_lvl(st_l), .pg_lvl(pg_l), .rst_lvl(rs_l),
		.low_len(lo_len));

	// ==========================================================
	// compare, bus and stimulus tasks
	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		checks++;
		if (g !== x) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chkb(string n, logic x, logic g);
		chk(n, {31'h0, x}, {31'h0, g});
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	// unbounded wait on pready is cut short by the watchdog
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(string n, logic [7:0] a, logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, x, r);
	endtask
	task automatic press(int n);
		btn_n <= 1'b0;
		cyc(n);
		btn_n <= 1'b1;
		cyc(2);
	endtask
	task automatic wait_rs(logic lv, int lim);
		i = 0;
		while (rs_l !== lv && i < lim) begin
			cyc(1);
			i++;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#280000;
		mismatches++;
		tally_and_finish();
	end

	// ==========================================================
	// tests
	initial begin
		cyc(2);
		rst_n <= 1'b1;
		rdc("ctrl", ADDR_CTRL, 32'h1);
		rdc("mask", ADDR_IRQ_MK, 32'h0);
		rdc("wake", ADDR_WAKE, {16'h0, WAKE2_RST, WAKE1_RST});
		rdc("tsth", ADDR_TSTH, TSTH_RST);
		rdc("term", ADDR_TERM, {27'h0, TERM_RST});
		rdc("hole", 8'h1c, 32'h0);
		chkb("hole_err", 1'b1, e);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("zone", 32'h2, {29'h0, r[6:4]});
		apb(1'b1, ADDR_TERM, 32'h3);
		cyc(2);
		chk("term_lo", {22'h0, TERM_MIN, TERM_MIN}, {22'h0, pre, term});
		apb(1'b1, ADDR_TERM, 32'h1f);
		cyc(2);
		chk("term_hi", {22'h0, TERM_MAX, TERM_MAX}, {22'h0, pre, term});
		chg <= 1'b1;
		cyc(3);
		chkb("chg_low", 1'b0, st_l);
		for (i = 0; i < 3; i++) begin
			{hiz, dis, done} <= 3'h1 << i;
			cyc(3);
			chkb("chg_rel", 1'b1, st_l);
		end
		{hiz, dis, done} <= 3'h0;
		apb(1'b1, ADDR_CTRL, 32'h0);
		cyc(3);
		chkb("ind_off", 1'b1, st_l);
		chg <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b1, ADDR_IRQ_MK, 32'h1);
		flt <= 1'b1;
		cyc(FC + 6);
		chk("pulse", FC, lo_len);
		chkb("irq_on", 1'b1, irq);
		flt <= 1'b0;
		apb(1'b1, ADDR_IRQ_ST, 32'h1);
		cyc(2);
		chkb("irq_off", 1'b0, irq);
		apb(1'b1, ADDR_IRQ_MK, 32'h0);
		flt <= 1'b1;
		cyc(FC + 6);
		chkb("irq_mask", 1'b0, irq);
		rdc("irq_st", ADDR_IRQ_ST, 32'h1);
		flt <= 1'b0;
		vin <= 1'b1;
		cyc(3);
		chkb("pg_in", 1'b0, pg_l);
		ovp <= 1'b1;
		cyc(3);
		chkb("pg_ovp", 1'b1, pg_l);
		apb(1'b1, ADDR_CTRL, 32'h3);
		btn_n <= 1'b0;
		cyc(3);
		chkb("pg_btn", 1'b0, pg_l);
		btn_n <= 1'b1;
		cyc(3);
		chkb("pg_rel", 1'b1, pg_l);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b1, ADDR_WAKE, 32'h0502);
		apb(1'b1, ADDR_IRQ_ST, 32'h1f);
		press(TK + TK / 2);
		press(TK + TK / 2);
		rdc("no_wake", ADDR_IRQ_ST, 32'h0);
		press(4 * TK);
		rdc("wake1", ADDR_IRQ_ST, 32'h2);
		apb(1'b1, ADDR_IRQ_ST, 32'h1f);
		press(7 * TK);
		rdc("wake2", ADDR_IRQ_ST, 32'h6);
		apb(1'b1, ADDR_IRQ_ST, 32'h1f);
		apb(1'b1, ADDR_CTRL, 32'h11);
		cyc(2);
		chkb("ship_in", 1'b1, ship);
		press(3);
		chkb("ship_out", 1'b0, ship);
		rdc("shipx", ADDR_IRQ_ST, 32'h10);
		apb(1'b1, ADDR_IRQ_ST, 32'h1f);
		btn_n <= 1'b0;
		cyc(4999 * TK);
		chkb("rst_early", 1'b1, rs_l);
		wait_rs(1'b0, 5 * TK);
		chkb("rst_on", 1'b0, rs_l);
		btn_n <= 1'b1;
		wait_rs(1'b1, 402 * TK);
		chkb("hold", 1'b1, i >= 399 * TK && i <= 401 * TK);
		rdc("long", ADDR_IRQ_ST, 32'he);
		apb(1'b1, ADDR_IRQ_ST, 32'h1f);
		therm <= 8'h10;
		chg <= 1'b1;
		cyc(4);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("ts_fault", 32'h1, {31'h0, r[7]});
		rdc("ts_irq", ADDR_IRQ_ST, 32'h1);
		chkb("pin_drive", 1'b0, st_d | pg_d | rs_d);
		tally_and_finish();
	end
endmodule

`default_nettype wire
